// file: pit_pkg.sv
// Shared constants and types for the program-memory and peripheral short transfer unit.
// Assumes a single core clock; every user of it imports the whole package.
`default_nettype none

package pit_pkg;

  // ****************************************************************
  // Widths and field layout
  // ****************************************************************
  localparam int DATA_W    = 16;
  localparam int ADDR_W    = 16;
  localparam int ACC_W     = 36;
  localparam int ACC_MSB   = 35;
  localparam int UPPER_MSB = 31;
  localparam int UPPER_LSB = 16;
  localparam int LOWER_MSB = 15;
  localparam int WORD_MSB  = 15;
  localparam int EXT_W     = 4;
  localparam int SHORT_W   = 6;
  localparam int PAGE_W    = 10;
  localparam int CNT_W     = 5;
  localparam int EXTRA_W   = 4;
  localparam int NUM_PTR   = 4;
  localparam int PTR_SEL_W = 2;

  // ****************************************************************
  // Values
  // ****************************************************************
  localparam logic [DATA_W-1:0] SAT_POS  = 16'h7fff;
  localparam logic [DATA_W-1:0] SAT_NEG  = 16'h8000;
  localparam logic [DATA_W-1:0] ZERO_W   = 16'h0000;
  localparam logic [DATA_W-1:0] STEP_ONE = 16'h0001;
  localparam logic [PAGE_W-1:0] IO_PAGE  = 10'h3ff;
  localparam logic [ACC_W-1:0]  ACC_RST  = 36'h0_0000_0000;

  // ****************************************************************
  // Cycle and word counts
  // ****************************************************************
  localparam logic [CNT_W-1:0] PM_BASE_CYC = 5'h08;
  localparam logic [CNT_W-1:0] IO_REG_CYC  = 5'h02;
  localparam logic [CNT_W-1:0] IO_IMM_CYC  = 5'h04;
  localparam logic [CNT_W-1:0] CNT_ONE     = 5'h01;
  localparam logic [CNT_W-1:0] CNT_ZERO    = 5'h00;
  localparam logic [1:0]       WORDS_ONE   = 2'h1;
  localparam logic [1:0]       WORDS_TWO   = 2'h2;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    OP_PM_READ,
    OP_PM_WRITE,
    OP_IO_READ,
    OP_IO_WRITE,
    OP_IO_IMM
  } pit_op_e;

  typedef enum logic [3:0] {
    REG_ACC_A,
    REG_ACC_B,
    REG_ACC_A_UP,
    REG_ACC_B_UP,
    REG_ACC_A_LO,
    REG_ACC_B_LO,
    REG_IN_X,
    REG_IN_Y0,
    REG_IN_Y1,
    REG_PTR0,
    REG_PTR1,
    REG_PTR2,
    REG_PTR3,
    REG_OFFSET
  } pit_reg_e;

  typedef enum logic {
    ST_IDLE,
    ST_RUN
  } pit_state_e;

endpackage

`default_nettype wire

// file: pit_sat_unit.sv
// Source word selection with accumulator limiting for 16-bit stores.
// Assumes the caller already resolved any non-accumulator source into word_i.
`timescale 1ns/1ns
`default_nettype none

module pit_sat_unit (
  input  wire pit_pkg::pit_reg_e          src_sel_i,
  input  wire logic [pit_pkg::ACC_W-1:0]  acc_a_i,
  input  wire logic [pit_pkg::ACC_W-1:0]  acc_b_i,
  input  wire logic [pit_pkg::DATA_W-1:0] word_i,
  output logic      [pit_pkg::DATA_W-1:0] word_o,
  output logic                            limited_o
);
  import pit_pkg::*;

  // ****************************************************************
  // Limiting
  // ****************************************************************
  // Extension in use when bits 35..31 disagree
  function automatic logic ext_used(input logic [ACC_W-1:0] acc);
    ext_used = !(&acc[ACC_MSB:UPPER_MSB]) && (|acc[ACC_MSB:UPPER_MSB]);
  endfunction

  function automatic logic [DATA_W-1:0] limit_word(input logic [ACC_W-1:0] acc);
    if (ext_used(acc)) begin
      limit_word = acc[ACC_MSB] ? SAT_NEG : SAT_POS;
    end else begin
      limit_word = acc[UPPER_MSB:UPPER_LSB];
    end
  endfunction

  always_comb begin
    word_o    = word_i;
    limited_o = 1'b0;
    case (src_sel_i)
      REG_ACC_A: begin
        word_o    = limit_word(acc_a_i);
        limited_o = ext_used(acc_a_i);
      end
      REG_ACC_B: begin
        word_o    = limit_word(acc_b_i);
        limited_o = ext_used(acc_b_i);
      end
      // Portion registers pass through untouched
      REG_ACC_A_UP: word_o = acc_a_i[UPPER_MSB:UPPER_LSB];
      REG_ACC_B_UP: word_o = acc_b_i[UPPER_MSB:UPPER_LSB];
      REG_ACC_A_LO: word_o = acc_a_i[LOWER_MSB:0];
      REG_ACC_B_LO: word_o = acc_b_i[LOWER_MSB:0];
      default: word_o = word_i;
    endcase
  end

endmodule

`default_nettype wire

// file: pit_move_unit.sv
// Execution unit for the program-memory transfer and the peripheral short transfer.
// Assumes synchronous memories that return read data the cycle after the read strobe.
`timescale 1ns/1ns
`default_nettype none

module pit_move_unit (
  input  wire logic                               clock_i,
  input  wire logic                               rst_n_i,
  input  wire logic                               start_i,
  input  wire pit_pkg::pit_op_e                   op_i,
  input  wire pit_pkg::pit_reg_e                  reg_sel_i,
  input  wire logic [pit_pkg::PTR_SEL_W-1:0]      ptr_sel_i,
  input  wire logic                               post_by_offset_i,
  input  wire logic [pit_pkg::SHORT_W-1:0]        io_short_address_i,
  input  wire logic [pit_pkg::DATA_W-1:0]         imm_word_i,
  input  wire logic [pit_pkg::EXTRA_W-1:0]        extra_cycles_i,
  input  wire logic                               execute_from_data_mem_i,
  input  wire logic                               load_en_i,
  input  wire pit_pkg::pit_reg_e                  load_sel_i,
  input  wire logic [pit_pkg::ACC_W-1:0]          load_data_i,
  input  wire logic [pit_pkg::DATA_W-1:0]         pm_rdata_i,
  input  wire logic [pit_pkg::DATA_W-1:0]         dm_rdata_i,
  output logic                                    busy_o,
  output logic                                    done_o,
  output logic                                    refused_o,
  output logic                                    limit_flag_o,
  output logic      [1:0]                         instr_words_o,
  output logic      [pit_pkg::ADDR_W-1:0]         pm_addr_o,
  output logic      [pit_pkg::DATA_W-1:0]         pm_wdata_o,
  output logic                                    pm_rd_o,
  output logic                                    pm_wr_o,
  output logic      [pit_pkg::ADDR_W-1:0]         dm_addr_o,
  output logic      [pit_pkg::DATA_W-1:0]         dm_wdata_o,
  output logic                                    dm_rd_o,
  output logic                                    dm_wr_o,
  output logic      [pit_pkg::ACC_W-1:0]          acc_a_o,
  output logic      [pit_pkg::ACC_W-1:0]          acc_b_o,
  output logic      [pit_pkg::DATA_W-1:0]         input_reg_x_o,
  output logic      [pit_pkg::DATA_W-1:0]         in_y0_o,
  output logic      [pit_pkg::DATA_W-1:0]         in_y1_o,
  output logic      [pit_pkg::DATA_W-1:0]         ptr0_o,
  output logic      [pit_pkg::DATA_W-1:0]         ptr1_o,
  output logic      [pit_pkg::DATA_W-1:0]         ptr2_o,
  output logic      [pit_pkg::DATA_W-1:0]         ptr3_o,
  output logic      [pit_pkg::DATA_W-1:0]         offset_o
);
  import pit_pkg::*;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic is_pm(input pit_op_e op);
    is_pm = (op == OP_PM_READ) || (op == OP_PM_WRITE);
  endfunction

  function automatic logic is_read(input pit_op_e op);
    is_read = (op == OP_PM_READ) || (op == OP_IO_READ);
  endfunction

  // Widen a word into a full accumulator
  function automatic logic [ACC_W-1:0] widen(input logic [DATA_W-1:0] w);
    widen = {{EXT_W{w[WORD_MSB]}}, w, ZERO_W};
  endfunction

  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [ACC_W-1:0]  acc_a_r;
  logic [ACC_W-1:0]  acc_b_r;
  logic [DATA_W-1:0] in_x_r;
  logic [DATA_W-1:0] in_y0_r;
  logic [DATA_W-1:0] in_y1_r;
  logic [DATA_W-1:0] ptr_r [NUM_PTR];
  logic [DATA_W-1:0] offset_r;
  logic              limit_r;

  pit_state_e           state_r;
  logic [CNT_W-1:0]     cnt_r;
  pit_op_e              op_r;
  pit_reg_e             reg_r;
  logic [PTR_SEL_W-1:0] ptr_sel_r;
  logic                 post_off_r;
  logic                 st_lim_r;
  logic                 cap_r;
  logic [DATA_W-1:0]    held_r;
  logic                 refused_r;
  logic [1:0]           words_r;

  logic [DATA_W-1:0] src_word;
  logic [DATA_W-1:0] sat_word;
  logic              sat_lim;
  logic [DATA_W-1:0] live_rdata;
  logic [DATA_W-1:0] rd_word;
  logic [CNT_W-1:0]  total_cyc;
  logic              req_pm;
  logic              accept;
  logic              refuse;
  logic              finish;

  // ****************************************************************
  // Request decode
  // ****************************************************************
  assign req_pm = is_pm(op_i);
  // A program-memory request while running from data memory is dropped
  assign refuse = (state_r == ST_IDLE) && start_i && req_pm && execute_from_data_mem_i;
  assign accept = (state_r == ST_IDLE) && start_i && !refuse;
  assign finish = (state_r == ST_RUN) && (cnt_r == CNT_ZERO);

  always_comb begin
    case (op_i)
      OP_PM_READ, OP_PM_WRITE: total_cyc = PM_BASE_CYC + CNT_W'(extra_cycles_i);
      OP_IO_IMM:               total_cyc = IO_IMM_CYC + CNT_W'(extra_cycles_i);
      default:                 total_cyc = IO_REG_CYC + CNT_W'(extra_cycles_i);
    endcase
  end

  // Non-accumulator source value; accumulators are resolved in the limiter
  always_comb begin
    case (reg_sel_i)
      REG_IN_X:   src_word = in_x_r;
      REG_IN_Y0:  src_word = in_y0_r;
      REG_IN_Y1:  src_word = in_y1_r;
      REG_PTR0:   src_word = ptr_r[0];
      REG_PTR1:   src_word = ptr_r[1];
      REG_PTR2:   src_word = ptr_r[2];
      REG_PTR3:   src_word = ptr_r[3];
      REG_OFFSET: src_word = offset_r;
      default:    src_word = ZERO_W;
    endcase
  end

  pit_sat_unit pit_sat_unit_inst (
    .src_sel_i (reg_sel_i),
    .acc_a_i   (acc_a_r),
    .acc_b_i   (acc_b_r),
    .word_i    (src_word),
    .word_o    (sat_word),
    .limited_o (sat_lim)
  );

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r    <= ST_IDLE;
      cnt_r      <= CNT_ZERO;
      op_r       <= OP_PM_READ;
      reg_r      <= REG_ACC_A;
      ptr_sel_r  <= '0;
      post_off_r <= 1'b0;
      st_lim_r   <= 1'b0;
      words_r    <= WORDS_ONE;
    end else if (accept) begin
      state_r    <= ST_RUN;
      cnt_r      <= total_cyc - CNT_ONE;
      op_r       <= op_i;
      reg_r      <= reg_sel_i;
      ptr_sel_r  <= ptr_sel_i;
      post_off_r <= post_by_offset_i;
      st_lim_r   <= (op_i == OP_IO_IMM) ? 1'b0 : sat_lim;
      words_r    <= (op_i == OP_IO_IMM) ? WORDS_TWO : WORDS_ONE;
    end else if (finish) begin
      state_r <= ST_IDLE;
    end else if (state_r == ST_RUN) begin
      cnt_r <= cnt_r - CNT_ONE;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      refused_r <= 1'b0;
    end else begin
      refused_r <= refuse;
    end
  end

  // ****************************************************************
  // Memory ports
  // ****************************************************************
  // Address taken from the pointer before the post-increment lands
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pm_addr_o  <= '0;
      pm_wdata_o <= ZERO_W;
      pm_rd_o    <= 1'b0;
      pm_wr_o    <= 1'b0;
      dm_addr_o  <= '0;
      dm_wdata_o <= ZERO_W;
      dm_rd_o    <= 1'b0;
      dm_wr_o    <= 1'b0;
    end else begin
      pm_rd_o <= accept && (op_i == OP_PM_READ);
      pm_wr_o <= accept && (op_i == OP_PM_WRITE);
      dm_rd_o <= accept && (op_i == OP_IO_READ);
      dm_wr_o <= accept && ((op_i == OP_IO_WRITE) || (op_i == OP_IO_IMM));
      if (accept && req_pm) begin
        pm_addr_o  <= ptr_r[ptr_sel_i];
        pm_wdata_o <= sat_word;
      end
      if (accept && !req_pm) begin
        dm_addr_o  <= {IO_PAGE, io_short_address_i};
        dm_wdata_o <= (op_i == OP_IO_IMM) ? imm_word_i : sat_word;
      end
    end
  end

  // Read data arrives one cycle after the strobe; hold it for longer forms
  assign live_rdata = is_pm(op_r) ? pm_rdata_i : dm_rdata_i;
  assign rd_word    = cap_r ? live_rdata : held_r;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cap_r  <= 1'b0;
      held_r <= ZERO_W;
    end else begin
      cap_r <= pm_rd_o || dm_rd_o;
      if (cap_r) begin
        held_r <= live_rdata;
      end
    end
  end

  // ****************************************************************
  // Register file
  // ****************************************************************
  // Post-increment first, so a load into the same pointer wins
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      acc_a_r  <= ACC_RST;
      acc_b_r  <= ACC_RST;
      in_x_r   <= ZERO_W;
      in_y0_r  <= ZERO_W;
      in_y1_r  <= ZERO_W;
      for (int i = 0; i < NUM_PTR; i++) begin
        ptr_r[i] <= ZERO_W;
      end
      offset_r <= ZERO_W;
    end else if (finish) begin
      if (is_pm(op_r)) begin
        ptr_r[ptr_sel_r] <= ptr_r[ptr_sel_r] + (post_off_r ? offset_r : STEP_ONE);
      end
      if (is_read(op_r)) begin
        case (reg_r)
          REG_ACC_A:    acc_a_r <= widen(rd_word);
          REG_ACC_B:    acc_b_r <= widen(rd_word);
          REG_ACC_A_UP: acc_a_r[UPPER_MSB:UPPER_LSB] <= rd_word;
          REG_ACC_B_UP: acc_b_r[UPPER_MSB:UPPER_LSB] <= rd_word;
          REG_IN_X:     in_x_r   <= rd_word;
          REG_IN_Y0:    in_y0_r  <= rd_word;
          REG_IN_Y1:    in_y1_r  <= rd_word;
          REG_PTR0:     ptr_r[0] <= rd_word;
          REG_PTR1:     ptr_r[1] <= rd_word;
          REG_PTR2:     ptr_r[2] <= rd_word;
          REG_PTR3:     ptr_r[3] <= rd_word;
          REG_OFFSET:   offset_r <= rd_word;
          default: begin
          end
        endcase
      end
    end else if ((state_r == ST_IDLE) && load_en_i && !start_i) begin
      // Raw preload path stands in for the rest of the core
      case (load_sel_i)
        REG_ACC_A:    acc_a_r  <= load_data_i;
        REG_ACC_B:    acc_b_r  <= load_data_i;
        REG_IN_X:     in_x_r   <= load_data_i[WORD_MSB:0];
        REG_IN_Y0:    in_y0_r  <= load_data_i[WORD_MSB:0];
        REG_IN_Y1:    in_y1_r  <= load_data_i[WORD_MSB:0];
        REG_PTR0:     ptr_r[0] <= load_data_i[WORD_MSB:0];
        REG_PTR1:     ptr_r[1] <= load_data_i[WORD_MSB:0];
        REG_PTR2:     ptr_r[2] <= load_data_i[WORD_MSB:0];
        REG_PTR3:     ptr_r[3] <= load_data_i[WORD_MSB:0];
        REG_OFFSET:   offset_r <= load_data_i[WORD_MSB:0];
        default: begin
        end
      endcase
    end
  end

  // ****************************************************************
  // Limit flag
  // ****************************************************************
  // Sticky: only reset clears it, so block floating-point code can test once
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      limit_r <= 1'b0;
    end else if (finish && !is_read(op_r) && st_lim_r) begin
      limit_r <= 1'b1;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign busy_o        = (state_r == ST_RUN);
  assign done_o        = finish;
  assign refused_o     = refused_r;
  assign limit_flag_o  = limit_r;
  assign instr_words_o = words_r;
  assign acc_a_o       = acc_a_r;
  assign acc_b_o       = acc_b_r;
  assign input_reg_x_o = in_x_r;
  assign in_y0_o       = in_y0_r;
  assign in_y1_o       = in_y1_r;
  assign ptr0_o        = ptr_r[0];
  assign ptr1_o        = ptr_r[1];
  assign ptr2_o        = ptr_r[2];
  assign ptr3_o        = ptr_r[3];
  assign offset_o      = offset_r;

endmodule

`default_nettype wire

// file: pit_mem_model.sv
// Program memory and top-page data memory facing the move unit.
// Assumes read data is wanted the cycle after the read strobe.
`timescale 1ns/1ns
`default_nettype none

// ****************************************************************
// Memory model
// ****************************************************************
module pit_mem_model (
  input  wire logic        clock_i,
  input  wire logic [15:0] pm_addr_i,
  input  wire logic [15:0] pm_wdata_i,
  input  wire logic        pm_rd_i,
  input  wire logic        pm_wr_i,
  output logic      [15:0] pm_rdata_o,
  input  wire logic [15:0] dm_addr_i,
  input  wire logic [15:0] dm_wdata_i,
  input  wire logic        dm_rd_i,
  input  wire logic        dm_wr_i,
  output logic      [15:0] dm_rdata_o
);
  logic [15:0] pmem [0:65535];
  logic [15:0] dmem [0:63];

  // Read data lasts one cycle; afterwards the bus toggles so stale data matches only every second cycle
  always @(posedge clock_i) begin
    pm_rdata_o <= pm_rd_i ? pmem[pm_addr_i] : ~pm_rdata_o;
    if (pm_wr_i) begin
      pmem[pm_addr_i] <= pm_wdata_i;
    end
  end

  // Only the top 64 words exist here, so a write to a wrong page is simply lost; reads ignore the page
  always @(posedge clock_i) begin
    dm_rdata_o <= dm_rd_i ? dmem[dm_addr_i[5:0]] : ~dm_rdata_o;
    if (dm_wr_i && dm_addr_i[15:6] == 10'h3ff) begin
      dmem[dm_addr_i[5:0]] <= dm_wdata_i;
    end
  end
endmodule

`default_nettype wire

// file: pit_move_unit_monitor.sv
// Concurrent checks on the ports of the move unit.
// Assumes one clock domain; bound to every move unit instance.
`timescale 1ns/1ns
`default_nettype none

// ****************************************************************
// Checker
// ****************************************************************
module pit_move_chk
  import pit_pkg::*;
(
  input wire logic              clock_i,
  input wire logic              rst_n_i,
  input wire logic              start_i,
  input wire pit_pkg::pit_op_e  op_i,
  input wire pit_pkg::pit_reg_e reg_sel_i,
  input wire logic [1:0]        ptr_sel_i,
  input wire logic              post_by_offset_i,
  input wire logic [3:0]        extra_cycles_i,
  input wire logic              execute_from_data_mem_i,
  input wire logic [15:0]       pm_rdata_i,
  input wire logic              busy_o,
  input wire logic              done_o,
  input wire logic              refused_o,
  input wire logic              limit_flag_o,
  input wire logic [1:0]        instr_words_o,
  input wire logic [15:0]       pm_addr_o,
  input wire logic              pm_rd_o,
  input wire logic [15:0]       dm_addr_o,
  input wire logic              dm_rd_o,
  input wire logic              dm_wr_o,
  input wire logic [35:0]       acc_a_o,
  input wire logic [15:0]       ptr0_o,
  input wire logic [15:0]       offset_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  wire take_w = start_i && !busy_o && extra_cycles_i == 4'h0;
  wire pm_w   = op_i == OP_PM_READ || op_i == OP_PM_WRITE;
  wire rd0_w  = take_w && op_i == OP_PM_READ && !execute_from_data_mem_i && ptr_sel_i == 2'h0;

  io_page_a: assert property ((dm_rd_o || dm_wr_o) |-> dm_addr_o[15:6] == 10'h3ff)
    else $error("peripheral address off the top page");
  limit_sticky_a: assert property (limit_flag_o |=> limit_flag_o)
    else $error("limit flag dropped");
  imm_words_a: assert property (take_w && op_i == OP_IO_IMM |=> instr_words_o == 2'h2)
    else $error("immediate form not two words");
  pm_len_a: assert property (rd0_w |=> (busy_o && !done_o)[*7] ##1 done_o)
    else $error("program transfer length wrong");
  io_len_a: assert property (take_w && op_i == OP_IO_WRITE |=> !done_o ##1 done_o)
    else $error("peripheral transfer length wrong");
  pm_refuse_a: assert property (start_i && !busy_o && pm_w && execute_from_data_mem_i
    |=> refused_o && !busy_o && !pm_rd_o) else $error("refused request went ahead");
  old_ptr_a: assert property (rd0_w |=> pm_rd_o && pm_addr_o == $past(ptr0_o))
    else $error("access did not use old pointer");
  ptr_step_a: assert property (rd0_w && reg_sel_i != REG_PTR0 |-> ##9
    ptr0_o == $past(ptr0_o, 9) + ($past(post_by_offset_i, 9) ? $past(offset_o, 9) : 16'h0001))
    else $error("pointer step wrong");
  acc_widen_a: assert property (rd0_w && reg_sel_i == REG_ACC_A |-> ##9
    acc_a_o[15:0] == 16'h0000 && acc_a_o[31:16] == $past(pm_rdata_i, 7)
    && (acc_a_o[35:31] == 5'h00 || acc_a_o[35:31] == 5'h1f)) else $error("widening wrong");

  cover property (done_o && instr_words_o == 2'h2);
  cover property (refused_o);
  cover property ($rose(limit_flag_o));
endmodule

bind pit_move_unit pit_move_chk pit_move_chk_inst (.*);

`default_nettype wire

// file: program_and_io_short_move_tb.sv
// Self-checking bench for the move unit with a memory model on its far side.
// Assumes pit_pkg, the design, the model and the checker are compiled first.
`timescale 1ns/1ns
`default_nettype none

module program_and_io_short_move_tb;
  import pit_pkg::*;
  logic        clock_i = 1'b0, rst_n_i = 1'b0, start_i = 1'b0, post_by_offset_i = 1'b0;
  pit_op_e     op_i = OP_IO_READ;
  pit_reg_e    reg_sel_i = REG_IN_X, load_sel_i = REG_IN_X;
  logic [1:0]  ptr_sel_i = 2'h0;
  logic [5:0]  io_short_address_i = 6'h00;
  logic [15:0] imm_word_i = 16'h0000;
  logic [3:0]  extra_cycles_i = 4'h0;
  logic        execute_from_data_mem_i = 1'b0, load_en_i = 1'b0;
  logic [35:0] load_data_i = 36'h0, acc_a_o, acc_b_o;
  logic        busy_o, done_o, refused_o, limit_flag_o, pm_rd_o, pm_wr_o, dm_rd_o, dm_wr_o;
  logic [1:0]  instr_words_o;
  logic [15:0] pm_rdata_i, dm_rdata_i, pm_addr_o, pm_wdata_o, dm_addr_o, dm_wdata_o;
  logic [15:0] input_reg_x_o, in_y0_o, in_y1_o, ptr0_o, ptr1_o, ptr2_o, ptr3_o, offset_o;
  logic [15:0] a1;
  logic        s1, r1;
  int          error_cnt = 0, checked = 0, cyc = 0, n = 0;

  pit_move_unit pit_move_unit_inst (.*);
  pit_mem_model pit_mem_model_inst (.clock_i(clock_i), .pm_addr_i(pm_addr_o),
    .pm_wdata_i(pm_wdata_o), .pm_rd_i(pm_rd_o), .pm_wr_i(pm_wr_o), .pm_rdata_o(pm_rdata_i),
    .dm_addr_i(dm_addr_o), .dm_wdata_i(dm_wdata_o), .dm_rd_i(dm_rd_o), .dm_wr_i(dm_wr_o),
    .dm_rdata_o(dm_rdata_i));

  always #20 clock_i = ~clock_i;

  // Whole run needs under two hundred cycles; the ceiling of 2000 leaves ample margin
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 2000) begin
      error_cnt++;
      stop_test();
    end
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk(input logic ok, input string m);
    checked++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask

  task automatic ld(input pit_reg_e s, input logic [35:0] d);
    @(posedge clock_i);
    load_en_i <= 1'b1;
    load_sel_i <= s;
    load_data_i <= d;
    @(posedge clock_i);
    load_en_i <= 1'b0;
  endtask

  // Counts run cycles up to done; a refused request simply times out at 40
  task automatic run(input pit_op_e op, input pit_reg_e r, input logic [1:0] p,
      input logic bo, input logic [3:0] ex, input logic [5:0] sa = 6'h00,
      input logic [15:0] im = 16'h0000);
    @(posedge clock_i);
    start_i <= 1'b1;
    op_i <= op;
    reg_sel_i <= r;
    ptr_sel_i <= p;
    post_by_offset_i <= bo;
    extra_cycles_i <= ex;
    io_short_address_i <= sa;
    imm_word_i <= im;
    @(posedge clock_i);
    start_i <= 1'b0;
    n = 0;
    do begin
      @(negedge clock_i);
      n++;
      if (n == 1) begin
        a1 = (pm_rd_o | pm_wr_o) ? pm_addr_o : dm_addr_o;
        s1 = pm_rd_o | pm_wr_o | dm_rd_o | dm_wr_o;
        r1 = refused_o;
      end
    end while (done_o !== 1'b1 && n < 40);
    @(negedge clock_i);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_pm_read;
    ld(REG_PTR0, 36'h77);
    ld(REG_OFFSET, 36'h3);
    ld(REG_ACC_A, 36'ha_1234_5678);
    pit_mem_model_inst.pmem[16'h0077] = 16'h8116;
    run(OP_PM_READ, REG_ACC_A, 2'h0, 1'b1, 4'h0);
    chk(n == 8 && a1 === 16'h0077, "pm read timing or address");
    chk(acc_a_o === 36'hf_8116_0000, "accumulator widening");
    chk(ptr0_o === 16'h007a, "pointer step by offset");
    ld(REG_PTR1, 36'h10);
    pit_mem_model_inst.pmem[16'h0010] = 16'h4321;
    pit_mem_model_inst.pmem[16'h0011] = 16'h1234;
    run(OP_PM_READ, REG_ACC_A_UP, 2'h1, 1'b0, 4'h3);
    chk(n == 11 && acc_a_o === 36'hf_4321_0000, "upper word load");
    run(OP_PM_READ, REG_PTR3, 2'h1, 1'b0, 4'h0);
    chk(ptr3_o === 16'h1234 && ptr1_o === 16'h0012, "pointer load and step");
    $display("pm read test done");
  endtask

  task automatic t_pm_write;
    ld(REG_PTR2, 36'h20);
    ld(REG_ACC_B, 36'h0_8000_0000);
    chk(limit_flag_o === 1'b0, "flag clear before limiting");
    run(OP_PM_WRITE, REG_ACC_B, 2'h2, 1'b0, 4'h0);
    chk(pit_mem_model_inst.pmem[16'h0020] === 16'h7fff, "positive limit");
    chk(limit_flag_o === 1'b1, "flag set");
    ld(REG_ACC_B, 36'hf_0000_1234);
    run(OP_PM_WRITE, REG_ACC_B, 2'h2, 1'b0, 4'h0);
    chk(pit_mem_model_inst.pmem[16'h0021] === 16'h8000, "negative limit");
    run(OP_PM_WRITE, REG_ACC_B_UP, 2'h2, 1'b0, 4'h0);
    chk(pit_mem_model_inst.pmem[16'h0022] === 16'h0000, "portion unlimited");
    chk(limit_flag_o === 1'b1, "flag sticky");
    $display("pm write test done");
  endtask

  task automatic t_io;
    ld(REG_IN_X, 36'h5555);
    run(OP_IO_WRITE, REG_IN_X, 2'h0, 1'b0, 4'h0, 6'h22);
    chk(n == 2 && a1 === 16'hffe2, "io write timing or address");
    chk(pit_mem_model_inst.dmem[6'h22] === 16'h5555, "io write data");
    run(OP_IO_IMM, REG_IN_X, 2'h0, 1'b0, 4'h0, 6'h3f, 16'h0342);
    chk(n == 4 && instr_words_o === 2'h2, "immediate cycles or words");
    chk(a1 === 16'hffff && pit_mem_model_inst.dmem[6'h3f] === 16'h0342, "imm");
    run(OP_IO_READ, REG_ACC_B, 2'h0, 1'b0, 4'h1, 6'h22);
    chk(n == 3 && acc_b_o === 36'h0_5555_0000, "io read");
    run(OP_IO_READ, REG_IN_Y0, 2'h0, 1'b0, 4'h0, 6'h3f);
    chk(in_y0_o === 16'h0342 && in_y1_o === 16'h0000, "word register read");
    chk(ptr2_o === 16'h0023, "pointer steps on writes");
    run(OP_IO_WRITE, REG_IN_X, 2'h0, 1'b0, 4'h0, 6'h00);
    chk(a1 === 16'hffc0 && instr_words_o === 2'h1, "low short address");
    $display("io test done");
  endtask

  task automatic t_refuse;
    @(posedge clock_i);
    execute_from_data_mem_i <= 1'b1;
    run(OP_PM_READ, REG_PTR0, 2'h0, 1'b0, 4'h0);
    chk(r1 === 1'b1 && s1 === 1'b0 && ptr0_o === 16'h007a, "refusal");
    run(OP_IO_WRITE, REG_IN_X, 2'h0, 1'b0, 4'h0, 6'h01);
    chk(n == 2 && s1 === 1'b1, "io allowed during refusal mode");
    @(posedge clock_i);
    execute_from_data_mem_i <= 1'b0;
    $display("refusal test done");
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge clock_i);
    rst_n_i <= 1'b1;
    chk(instr_words_o === 2'h1 && limit_flag_o === 1'b0, "reset values");
    t_pm_read();
    t_pm_write();
    t_io();
    t_refuse();
    stop_test();
  end
endmodule

`default_nettype wire
